/* File: rtl/ifq_fetch_queue.v */
// Instruction fetch queue: program fetch, byte ring, decode window and loops
//
// Summary of operation
// RL1 - Program fetch colliding with multi-operand data access in same block waits one cycle
// RL2 - Queue ring holds at least 56 bytes so small loop bodies stay resident
// RL3 - Long-operand access counts as one address, so alone it never blocks a fetch from a dual block
// RL4 - Queue is filled by 32-bit packets read from word-aligned addresses
// RL5 - Decode sees a 48-bit window and removes exactly its instruction length
// RL6 - Undecoded byte count is tracked; decode stalls when it does not exceed next length
// RL7 - Fetch advance stays in 0..24 bytes; fetching pauses at the maximum
// RL8 - A program-counter discontinuity flushes the queue and refetches from the target
// RL9 - First packet lacking pair, or instruction plus next byte, costs one delay cycle
// RL10 - A first target instruction of four bytes or more costs one delay cycle
// RL11 - Block repeat fetches seven bytes past the last instruction address, then waits
// RL12 - Local repeat loops show no surplus-fetch delay and never refetch their body
// RL13 - One packet per cycle sustains four bytes per cycle of decode
// RL14 - Local loop span at most 55 bytes, total size at most 61 bytes
// RL15 - During a local loop sequential fetching continues until the advance reaches 24
// RL16 - Iterations of a resident local loop see no queue stall
// RL17 - Decode units are one to six bytes; a parallel pair counts as one unit
`timescale 1ns/1ps
`include "ifq_map.vh"

module ifq_fetch_queue (
  // Clock and reset
  input  wire                   sys_clk_in,
  input  wire                   reset_n_in,
  // Program memory port
  output wire                   fetch_req_out,
  output reg  [`IFQ_ADDR_W-1:0] fetch_addr_out,
  input  wire                   fetch_valid_in,
  input  wire [`IFQ_PKT_W-1:0]  fetch_data_in,
  input  wire                   fetch_block_dual_in,
  // Data access seen at the same memory
  input  wire                   data_read_addr_valid_in,
  input  wire                   data_write_addr_valid_in,
  input  wire                   data_coef_valid_in,
  input  wire                   data_long_in,
  input  wire [`IFQ_ADDR_W-1:0] data_addr_in,
  // Discontinuity
  input  wire                   flush_in,
  input  wire [`IFQ_ADDR_W-1:0] flush_addr_in,
  input  wire [2:0]             flush_first_len_in,
  input  wire                   flush_first_pair_in,
  // Block repeat
  input  wire                   brpt_active_in,
  input  wire [`IFQ_ADDR_W-1:0] brpt_last_addr_in,
  // Local repeat
  input  wire                   lrpt_begin_in,
  input  wire                   lrpt_active_in,
  input  wire [6:0]             lrpt_size_in,
  input  wire [6:0]             lrpt_span_in,
  output wire                   lrpt_resident_out,
  output reg                    lrpt_error_out,
  // Decode stage
  output wire [`IFQ_WIN_W-1:0]  dec_window_out,
  output wire                   dec_stall_out,
  input  wire [2:0]             dec_next_len_in,
  input  wire                   dec_take_in,
  input  wire [2:0]             dec_take_len_in,
  output wire [6:0]             fetch_advance_out
);

  // Byte ring; 64 physical bytes so pointers wrap naturally
  reg  [7:0]             ring [0:63];
  reg  [`IFQ_PTR_W-1:0]  rd_ptr;
  reg  [`IFQ_PTR_W-1:0]  wr_ptr;
  reg  [`IFQ_PTR_W-1:0]  loop_start;
  reg  [`IFQ_PTR_W-1:0]  loop_size;
  reg                    loop_on;
  reg  [1:0]             live_cnt;
  reg  [1:0]             stale_cnt;
  reg                    first_pending;
  reg  [1:0]             first_offset;
  reg  [2:0]             first_len;
  reg                    first_pair;
  reg                    disc_delay;

  reg  [`IFQ_PTR_W-1:0]  next_rd_ptr;
  reg  [`IFQ_PTR_W-1:0]  next_wr_ptr;
  reg  [1:0]             next_live_cnt;
  reg  [1:0]             next_stale_cnt;

  wire                   buf_in_ready;
  wire                   buf_out_valid;
  wire                   buf_out_ready;
  wire [`IFQ_PKT_W-1:0]  buf_out_data;
  wire [1:0]             buf_count;

  // Undecoded bytes and the bytes the ring must still keep
  wire [`IFQ_PTR_W-1:0] raw_adv   = wr_ptr - rd_ptr;
  // Until the first packet lands the read pointer sits ahead by the target offset,
  // and a resident loop's wrapped read pointer overstates it, so clamp to the range
  wire [`IFQ_PTR_W-1:0] advance   = first_pending ? `IFQ_PTR_RST
                                  : (raw_adv > `IFQ_MAX_ADVANCE) ? `IFQ_MAX_ADVANCE
                                  : raw_adv;                                      // RL7
  wire [`IFQ_PTR_W-1:0] keep_ptr  = loop_on ? loop_start : rd_ptr;
  wire [`IFQ_PTR_W-1:0] held      = wr_ptr - keep_ptr;
  wire [`IFQ_PTR_W-1:0] loop_end  = loop_start + loop_size;
  wire                  resident  = loop_on && ((wr_ptr - loop_start) >= loop_size);

  assign lrpt_resident_out = resident;
  assign fetch_advance_out = advance;

  // Packets already asked for but not yet in the ring
  wire [2:0] pend_pkts = {1'b0, live_cnt} + {1'b0, buf_count};
  wire [`IFQ_PTR_W-1:0] pend_bytes = {2'b00, pend_pkts, 2'b00};

  // Conflict: a dual block tolerates one data address, a single block none.
  // A long operand drives one address for both words.
  wire [1:0] addr_uses = {1'b0, data_read_addr_valid_in}
                       + {1'b0, data_write_addr_valid_in & ~data_long_in}
                       + {1'b0, data_coef_valid_in};                              // RL3
  wire [1:0] data_load = (data_long_in && data_write_addr_valid_in
                          && !data_read_addr_valid_in) ? 2'h1 : addr_uses;       // RL3
  wire same_block = (fetch_addr_out[`IFQ_ADDR_W-1:`IFQ_BLK_LSB]
                     == data_addr_in[`IFQ_ADDR_W-1:`IFQ_BLK_LSB]);
  wire conflict   = same_block && (fetch_block_dual_in ? (data_load >= 2'h2)
                                                       : (data_load != 2'h0));  // RL1

  // Advance cap counts bytes in flight so the advance never runs past 24
  wire room_adv  = (advance + pend_bytes + `IFQ_PKT_BYTES) <= `IFQ_MAX_ADVANCE;   // RL7 RL15
  wire room_ring = (held + pend_bytes + `IFQ_PKT_BYTES) <= `IFQ_RING_BYTES;       // RL2
  // Block repeat: the end address is known, the last length is not
  wire brpt_stop = brpt_active_in
                   && (fetch_addr_out > (brpt_last_addr_in + `IFQ_BRPT_SURPLUS)); // RL11
  // A resident local loop never refetches its body
  wire slot_free = (pend_pkts < 3'h2)
                   || ((pend_pkts == 3'h2) && buf_out_valid && buf_out_ready);

  assign fetch_req_out = reset_n_in && !flush_in && room_adv && room_ring
                         && !brpt_stop && slot_free && !conflict;                // RL1 RL13

  // Stale returns after a flush are dropped before the buffer
  wire stale    = (stale_cnt != 2'h0);
  wire ret_live = fetch_valid_in && !stale;

  ifq_pkt_buffer u_pkt_buffer (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .flush_in      (flush_in),
    .in_valid_in   (ret_live && !flush_in),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (fetch_data_in),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (buf_out_ready),
    .out_data_out  (buf_out_data),
    .count_out     (buf_count)
  );

  // Buffer drains only when the ring has space; this back-pressures fetch
  assign buf_out_ready = !flush_in && ((held + `IFQ_PKT_BYTES) <= `IFQ_RING_BYTES);
  wire pkt_write = buf_out_valid && buf_out_ready;

  // Ring index for window byte k, folding back at a resident loop's end
  function [`IFQ_IDX_W-1:0] win_idx;
    input [`IFQ_PTR_W-1:0] base;
    input [2:0]            k;
    input                  fold;
    input [`IFQ_PTR_W-1:0] lend;
    input [`IFQ_PTR_W-1:0] lsize;
    reg   [`IFQ_PTR_W-1:0] p;
    begin
      p = base + {4'h0, k};
      if (fold && ((p - (lend - lsize)) >= lsize)) begin
        p = p - lsize;
      end
      win_idx = p[`IFQ_IDX_W-1:0];
    end
  endfunction

  // Six-byte decode window, lowest address in the low byte
  genvar gk;
  generate
    for (gk = 0; gk < 6; gk = gk + 1) begin : g_win
      assign dec_window_out[gk*8 +: 8] =
        ring[win_idx(rd_ptr, gk[2:0], resident, loop_end, loop_size)];        // RL5
    end
  endgenerate

  // Stall when undecoded bytes do not exceed the next length;
  // a resident loop already holds every byte it will decode
  wire short_data = (advance <= {4'h0, dec_next_len_in});                         // RL6
  assign dec_stall_out = first_pending || disc_delay
                         || (short_data && !resident);                            // RL6 RL16

  // Legal take: one to six bytes, not during a stall
  wire take = dec_take_in && !dec_stall_out && !flush_in
              && (dec_take_len_in != 3'h0) && (dec_take_len_in <= 3'h6);          // RL17

  // First packet test after a discontinuity
  wire [2:0] first_avail = 3'h4 - {1'b0, first_offset};
  wire first_fits = first_pair ? (first_len <= first_avail)
                               : ({1'b0, first_len} + 4'h1 <= {1'b0, first_avail}); // RL9
  wire first_slow = !first_fits || (first_len >= `IFQ_LONG_INSTR);               // RL9 RL10

  // Read and write pointer updates
  always @* begin
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    if (flush_in) begin
      next_wr_ptr = `IFQ_PTR_RST;
      next_rd_ptr = {5'h00, flush_addr_in[1:0]};                                 // RL8
    end else begin
      if (pkt_write) begin
        next_wr_ptr = wr_ptr + `IFQ_PKT_BYTES;                                    // RL4
      end
      if (take) begin
        next_rd_ptr = rd_ptr + {4'h0, dec_take_len_in};                           // RL5
        if (resident && lrpt_active_in && ((next_rd_ptr - loop_start) >= loop_size)) begin
          next_rd_ptr = next_rd_ptr - loop_size;                                  // RL12 RL16
        end
      end
    end
  end

  // Outstanding fetch accounting; old returns are charged to the flush
  always @* begin
    next_live_cnt  = live_cnt;
    next_stale_cnt = stale_cnt;
    if (flush_in) begin
      next_stale_cnt = stale_cnt + live_cnt - {1'b0, ret_live} - {1'b0, fetch_valid_in & stale};
      next_live_cnt  = `IFQ_CNT_RST;                                              // RL8
    end else begin
      next_stale_cnt = stale_cnt - {1'b0, fetch_valid_in & stale};
      next_live_cnt  = live_cnt + {1'b0, fetch_req_out} - {1'b0, ret_live};
    end
  end

  // Pointers, counters and fetch address
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rd_ptr         <= `IFQ_PTR_RST;
      wr_ptr         <= `IFQ_PTR_RST;
      live_cnt       <= `IFQ_CNT_RST;
      stale_cnt      <= `IFQ_CNT_RST;
      fetch_addr_out <= `IFQ_ADDR_RST;
    end else begin
      rd_ptr    <= next_rd_ptr;
      wr_ptr    <= next_wr_ptr;
      live_cnt  <= next_live_cnt;
      stale_cnt <= next_stale_cnt;
      if (flush_in) begin
        fetch_addr_out <= {flush_addr_in[`IFQ_ADDR_W-1:2], 2'b00};               // RL4 RL8
      end else if (fetch_req_out) begin
        fetch_addr_out <= fetch_addr_out + 24'h00_0004;                          // RL13
      end
    end
  end

  // Packet bytes land in the ring, little end first
  integer bi;
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      for (bi = 0; bi < 64; bi = bi + 1) begin
        ring[bi] <= 8'h00;
      end
    end else if (pkt_write) begin
      for (bi = 0; bi < 4; bi = bi + 1) begin
        ring[wr_ptr[`IFQ_IDX_W-1:0] + bi[`IFQ_IDX_W-1:0]] <= buf_out_data[bi*8 +: 8]; // RL4
      end
    end
  end

  // Discontinuity delay: armed by the flush, judged on the first packet
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      first_pending <= 1'b0;
      first_offset  <= 2'h0;
      first_len     <= 3'h0;
      first_pair    <= 1'b0;
      disc_delay    <= 1'b0;
    end else if (flush_in) begin
      first_pending <= 1'b1;                                                      // RL8
      first_offset  <= flush_addr_in[1:0];
      first_len     <= flush_first_len_in;
      first_pair    <= flush_first_pair_in;
      disc_delay    <= 1'b0;
    end else if (first_pending && pkt_write) begin
      first_pending <= 1'b0;
      disc_delay    <= first_slow;                                                // RL9 RL10
    end else begin
      disc_delay    <= 1'b0;
    end
  end

  // Local loop capture; a flush ends it since the body left the ring
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      loop_on        <= 1'b0;
      loop_start     <= `IFQ_PTR_RST;
      loop_size      <= `IFQ_PTR_RST;
      lrpt_error_out <= 1'b0;
    end else if (flush_in) begin
      loop_on <= 1'b0;
    end else if (lrpt_begin_in) begin
      // Oversize loop is flagged and run as plain sequential code
      if ((lrpt_span_in > `IFQ_LRPT_SPAN_MAX) || (lrpt_size_in > `IFQ_LRPT_SIZE_MAX)
          || (lrpt_size_in == 7'h00)) begin                                       // RL14
        loop_on        <= 1'b0;
        lrpt_error_out <= 1'b1;
      end else begin
        loop_on        <= 1'b1;                                                   // RL12
        loop_start     <= rd_ptr;
        loop_size      <= lrpt_size_in;
        lrpt_error_out <= 1'b0;
      end
    end else if (loop_on && !lrpt_active_in) begin
      // Last pass done: release the body so fetch space reopens
      loop_on <= 1'b0;
    end
  end

endmodule // ifq_fetch_queue

/* File: rtl/ifq_map.vh */
// Constants shared by the instruction fetch queue and its packet buffer
`ifndef IFQ_MAP_VH
`define IFQ_MAP_VH

// Widths
`define IFQ_ADDR_W        24
`define IFQ_PKT_W         32
`define IFQ_WIN_W         48
`define IFQ_PTR_W         7
`define IFQ_IDX_W         6
`define IFQ_BLK_LSB       13

// Queue geometry in bytes
`define IFQ_RING_BYTES    7'h40
`define IFQ_LOOP_BYTES    7'h38
`define IFQ_PKT_BYTES     7'h04
`define IFQ_WIN_BYTES     7'h06
`define IFQ_MAX_ADVANCE   7'h18

// Loop and discontinuity figures
`define IFQ_BRPT_SURPLUS  24'h00_0007
`define IFQ_LRPT_SPAN_MAX 7'h37
`define IFQ_LRPT_SIZE_MAX 7'h3d
`define IFQ_LONG_INSTR    3'h4

// Reset values
`define IFQ_PTR_RST       7'h00
`define IFQ_ADDR_RST      24'h00_0000
`define IFQ_CNT_RST       2'h0

`endif

/* File: rtl/ifq_pkt_buffer.v */
// Two-entry packet buffer between program memory and the fetch queue
`timescale 1ns/1ps
`include "ifq_map.vh"

module ifq_pkt_buffer (
  // Clock and reset
  input  wire                   sys_clk_in,
  input  wire                   reset_n_in,
  input  wire                   flush_in,
  // Filling side
  input  wire                   in_valid_in,
  output wire                   in_ready_out,
  input  wire [`IFQ_PKT_W-1:0]  in_data_in,
  // Draining side
  output wire                   out_valid_out,
  input  wire                   out_ready_in,
  output wire [`IFQ_PKT_W-1:0]  out_data_out,
  output wire [1:0]             count_out
);

  reg [`IFQ_PKT_W-1:0] entry0;
  reg [`IFQ_PKT_W-1:0] entry1;
  reg [1:0]            count;

  wire push = in_valid_in & in_ready_out;
  wire pop  = out_valid_out & out_ready_in;

  assign in_ready_out  = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out  = entry0;
  assign count_out     = count;

  // Head is entry0; a push while full is refused by in_ready
  always @(posedge sys_clk_in) begin
    if (!reset_n_in || flush_in) begin
      count  <= `IFQ_CNT_RST;
      entry0 <= {`IFQ_PKT_W{1'b0}};
      entry1 <= {`IFQ_PKT_W{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count == 2'h0) entry0 <= in_data_in;
          else               entry1 <= in_data_in;
          count <= count + 2'h1;
        end
        2'b01: begin
          entry0 <= entry1;
          count  <= count - 2'h1;
        end
        2'b11: begin
          if (count == 2'h1) entry0 <= in_data_in;
          else begin
            entry0 <= entry1;
            entry1 <= in_data_in;
          end
        end
        default: begin
          count <= count;
        end
      endcase
    end
  end

endmodule // ifq_pkt_buffer

/* File: bench/ifq_chk.sv */
// Port-level assertions of the instruction fetch queue
`timescale 1ns/1ps
module ifq_chk (
  // Clock and reset
  input wire        sys_clk_in,
  input wire        reset_n_in,
  // Memory and data access
  input wire        fetch_req_out,
  input wire [23:0] fetch_addr_out,
  input wire        fetch_block_dual_in,
  input wire        data_read_addr_valid_in,
  input wire        data_write_addr_valid_in,
  input wire        data_coef_valid_in,
  input wire        data_long_in,
  input wire [23:0] data_addr_in,
  // Flow control and decode
  input wire        flush_in,
  input wire [23:0] flush_addr_in,
  input wire [2:0]  flush_first_len_in,
  input wire        brpt_active_in,
  input wire [23:0] brpt_last_addr_in,
  input wire        lrpt_begin_in,
  input wire [6:0]  lrpt_size_in,
  input wire [6:0]  lrpt_span_in,
  input wire        lrpt_resident_out,
  input wire        lrpt_error_out,
  input wire        dec_stall_out,
  input wire [2:0]  dec_next_len_in,
  input wire [6:0]  fetch_advance_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Data use of the fetched block; a long operand on a dual block uses one bus only
  wire same_blk = fetch_addr_out[23:13] == data_addr_in[23:13];
  wire any_use  = data_read_addr_valid_in | data_write_addr_valid_in | data_coef_valid_in;
  wire dual_hit = data_read_addr_valid_in & data_coef_valid_in & !data_long_in;
  property p_conflict;
    same_blk && (fetch_block_dual_in ? dual_hit : any_use) |-> !fetch_req_out;
  endproperty
  property p_align;
    fetch_req_out |-> fetch_addr_out[1:0] == 2'h0;
  endproperty
  property p_adv_range;
    fetch_advance_out <= 7'h18;
  endproperty
  property p_pause;
    fetch_advance_out > 7'h14 |-> !fetch_req_out;
  endproperty
  property p_stall;
    !lrpt_resident_out && fetch_advance_out <= {4'h0, dec_next_len_in} |-> dec_stall_out;
  endproperty
  // Flush empties the queue and restarts at the aligned target
  property p_flush;
    flush_in |-> !fetch_req_out ##1
      (fetch_addr_out == {$past(flush_addr_in[23:2]), 2'h0} && fetch_advance_out == 7'h00);
  endproperty
  property p_long_first;
    flush_in && flush_first_len_in >= 3'h4 |=> dec_stall_out [*4];
  endproperty
  property p_surplus;
    brpt_active_in && fetch_req_out |-> fetch_addr_out <= brpt_last_addr_in + 24'h00_0007;
  endproperty
  property p_loop_err;
    lrpt_begin_in |=> lrpt_error_out == ($past(lrpt_size_in) > 7'h3d || $past(lrpt_span_in) > 7'h37);
  endproperty
  a_conflict: assert property (p_conflict) else $error("fetch during conflict");
  a_align: assert property (p_align) else $error("unaligned fetch");
  a_adv_range: assert property (p_adv_range) else $error("advance above limit");
  a_pause: assert property (p_pause) else $error("fetch at full advance");
  a_stall: assert property (p_stall) else $error("decode not stalled");
  a_flush: assert property (p_flush) else $error("bad restart after flush");
  a_long_first: assert property (p_long_first) else $error("no delay on long target");
  a_surplus: assert property (p_surplus) else $error("fetch past surplus");
  a_loop_err: assert property (p_loop_err) else $error("loop size flag wrong");
  c_flush: cover property (flush_in ##1 fetch_req_out);
  c_full: cover property (fetch_advance_out == 7'h18);
  c_resident: cover property (lrpt_resident_out && !dec_stall_out);
  c_conflict: cover property (same_blk && any_use && !fetch_req_out);
endmodule // ifq_chk

/* File: bench/ifq_prog_mem.sv */
// Program memory model answering each fetch after one or two cycles
`timescale 1ns/1ps
module ifq_prog_mem (
  // Clock and answer speed
  input  wire        sys_clk_in,
  input  wire        slow_in,
  // Fetch request
  input  wire        fetch_req_in,
  input  wire [23:0] fetch_addr_in,
  // Packet answer
  output wire        fetch_valid_out,
  output wire [31:0] fetch_data_out
);
  reg        s1_v = 1'b0;
  reg        s2_v = 1'b0;
  reg [23:0] s1_a, s2_a;
  wire [23:0] pkt_addr = slow_in ? s2_a : s1_a;
  function [7:0] mbyte(input [23:0] x);
    mbyte = x[7:0] ^ x[15:8];
  endfunction
  // Two stages keep order; speed only changes while the queue is in reset
  always @(posedge sys_clk_in) begin
    s1_v <= fetch_req_in;
    s1_a <= fetch_addr_in;
    s2_v <= s1_v;
    s2_a <= s1_a;
  end
  // Lowest address in the low byte; data is inverted when no packet stands
  assign fetch_valid_out = slow_in ? s2_v : s1_v;
  assign fetch_data_out  = {mbyte(pkt_addr + 24'h00_0003), mbyte(pkt_addr + 24'h00_0002),
    mbyte(pkt_addr + 24'h00_0001), mbyte(pkt_addr)} ^ {32{~fetch_valid_out}};
endmodule // ifq_prog_mem

/* File: bench/instruction_buffer_fetch_queue_test.sv */
// Self-checking bench of the instruction fetch queue
`timescale 1ns/1ps
module instruction_buffer_fetch_queue_test;
  // Design ports and bench state
  reg         sys_clk_in, reset_n_in, fetch_block_dual_in, data_long_in, flush_in, slow;
  reg         data_read_addr_valid_in, data_write_addr_valid_in, data_coef_valid_in;
  reg         flush_first_pair_in, brpt_active_in, lrpt_begin_in, lrpt_active_in, dec_take_in;
  reg  [23:0] data_addr_in, flush_addr_in, brpt_last_addr_in, pc, lstart, a;
  reg  [2:0]  flush_first_len_in, dec_next_len_in, dec_take_len_in;
  reg  [6:0]  lrpt_size_in, lrpt_span_in;
  wire        fetch_req_out, fetch_valid_in, dec_stall_out, lrpt_resident_out, lrpt_error_out;
  wire [23:0] fetch_addr_out;
  wire [31:0] fetch_data_in;
  wire [47:0] dec_window_out;
  wire [6:0]  fetch_advance_out;
  integer     n_mismatch, check_count, i, k, t;
  ifq_fetch_queue i_ifq_fetch_queue (.sys_clk_in, .reset_n_in, .fetch_req_out, .fetch_addr_out,
    .fetch_valid_in, .fetch_data_in, .fetch_block_dual_in, .data_read_addr_valid_in,
    .data_write_addr_valid_in, .data_coef_valid_in, .data_long_in, .data_addr_in, .flush_in,
    .flush_addr_in, .flush_first_len_in, .flush_first_pair_in, .brpt_active_in,
    .brpt_last_addr_in, .lrpt_begin_in, .lrpt_active_in, .lrpt_size_in, .lrpt_span_in,
    .lrpt_resident_out, .lrpt_error_out, .dec_window_out, .dec_stall_out, .dec_next_len_in,
    .dec_take_in, .dec_take_len_in, .fetch_advance_out);
  ifq_prog_mem i_ifq_prog_mem (.sys_clk_in, .slow_in(slow), .fetch_req_in(fetch_req_out),
    .fetch_addr_in(fetch_addr_out), .fetch_valid_out(fetch_valid_in),
    .fetch_data_out(fetch_data_in));
  // Expected window: six bytes of the memory pattern from the decode address
  // A resident loop folds bytes past its end back to its start
  function [47:0] ewin(input [23:0] x, input f);
    integer j;
    reg [23:0] y;
    for (j = 0; j < 6; j = j + 1) begin
      y = x + j;
      if (f && y >= lstart + lrpt_size_in) y = y - lrpt_size_in;
      ewin[8*j +: 8] = y[7:0] ^ y[15:8];
    end
  endfunction
  task fail(input [8*24-1:0] m);
    begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: %0s", $time, m);
    end
  endtask
  task chk_win(input [47:0] e);
    begin
      check_count = check_count + 1;
      if (dec_window_out !== e) fail("decode window");
    end
  endtask
  task chk_bit(input g, input e, input [8*24-1:0] m);
    begin
      check_count = check_count + 1;
      if (g !== e) fail(m);
    end
  endtask
  task tally_and_finish;
    begin
      if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // Discontinuity to x with a random first unit
  task jump(input [23:0] x);
    begin
      @(negedge sys_clk_in);
      dec_take_in = 0;
      flush_in = 1;
      flush_addr_in = x;
      flush_first_len_in = 3'h1 + $urandom % 6;
      flush_first_pair_in = $urandom;
      pc = x;
      @(negedge sys_clk_in);
      flush_in = 0;
    end
  endtask
  // Random data traffic and decode; lp decodes 4-byte units and wraps at the loop end
  task run(input integer n, input lp);
    for (t = 0; t < n; t = t + 1) begin
      @(negedge sys_clk_in);
      dec_take_in = 0;
      fetch_block_dual_in = $urandom;
      {data_read_addr_valid_in, data_write_addr_valid_in, data_coef_valid_in, data_long_in} =
        ($urandom % 4 == 0) ? $urandom : 0;
      data_addr_in = $urandom % 2 ? fetch_addr_out : $urandom;
      dec_next_len_in = lp ? 3'h4 : 3'h1 + $urandom % 6;
      #1;
      if (fetch_advance_out >= 7'h06 && dec_stall_out === 1'b0) chk_win(ewin(pc, lp));
      if (lp && lrpt_resident_out === 1'b1) chk_bit(dec_stall_out, 1'b0, "resident stall");
      if (dec_stall_out === 1'b0) begin
        // A length of seven must be ignored, so the address stays put
        dec_take_in = 1;
        dec_take_len_in = (t % 17 == 5) ? 3'h7 : dec_next_len_in;
        if (t % 17 != 5) pc = pc + dec_next_len_in;
        if (lp && pc == lstart + lrpt_size_in) pc = lstart;
      end
    end
  endtask
  initial begin
    sys_clk_in = 0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    {reset_n_in, fetch_block_dual_in, data_long_in, flush_in, slow, data_read_addr_valid_in,
      data_write_addr_valid_in, data_coef_valid_in, flush_first_pair_in, brpt_active_in,
      lrpt_begin_in, lrpt_active_in, dec_take_in} = 13'h0000;
    {data_addr_in, flush_addr_in, brpt_last_addr_in, pc, lstart, a} = 144'h0;
    {flush_first_len_in, dec_next_len_in, dec_take_len_in} = 9'h049;
    {lrpt_size_in, lrpt_span_in} = 14'h0000;
    n_mismatch = 0;
    check_count = 0;
    k = $urandom(47);
    // Second pass resets in mid-run and answers fetches a cycle later
    for (i = 0; i < 2; i = i + 1) begin
      @(negedge sys_clk_in);
      reset_n_in = 0;
      lrpt_active_in = 0;
      slow = i;
      repeat (8) @(negedge sys_clk_in);
      reset_n_in = 1;
      for (k = 0; k < 12; k = k + 1) begin
        a = k == 0 ? 24'h00_1ffd : k == 1 ? 24'h00_4000 : $urandom % 65536;
        brpt_active_in = k % 3 == 1;
        brpt_last_addr_in = a + 24'h00_0010;
        jump(a);
        run(60, 0);
        if (brpt_active_in) chk_bit(fetch_req_out, 1'b0, "fetch past loop end");
      end
      brpt_active_in = 0;
      jump(24'h00_2000 + i);
      // Oversize loop is flagged, then a 56-byte loop must become resident
      for (k = 0; k < 2; k = k + 1) begin
        @(negedge sys_clk_in);
        lrpt_begin_in = 1;
        {lrpt_size_in, lrpt_span_in} = k ? {7'h38, 7'h34} : {7'h3e, 7'h37};
        @(negedge sys_clk_in);
        lrpt_begin_in = 0;
        #1 chk_bit(lrpt_error_out, k == 0, "loop size flag");
      end
      lstart = pc;
      lrpt_active_in = 1;
      run(150, 1);
      chk_bit(lrpt_resident_out, 1'b1, "loop not resident");
    end
    tally_and_finish;
  end
endmodule // instruction_buffer_fetch_queue_test
bind ifq_fetch_queue ifq_chk i_ifq_chk (.sys_clk_in, .reset_n_in, .fetch_req_out, .fetch_addr_out,
  .fetch_block_dual_in, .data_read_addr_valid_in, .data_write_addr_valid_in, .data_coef_valid_in,
  .data_long_in, .data_addr_in, .flush_in, .flush_addr_in, .flush_first_len_in, .brpt_active_in,
  .brpt_last_addr_in, .lrpt_begin_in, .lrpt_size_in, .lrpt_span_in, .lrpt_resident_out,
  .lrpt_error_out, .dec_stall_out, .dec_next_len_in, .fetch_advance_out);
